/* File: src/sttm_pkg.sv */
// constants and types for the safety tap channel monitor
package sttm_pkg;

  // ==========================================================
  // channels and nodes
  localparam int NUM_CH = 3;
  localparam int MAX_NODES = 32;
  localparam int CNT_W = 6;
  localparam int L2_ONLY_CH = 2;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
  localparam int TICK_W = 18;
  localparam int DISC_S = 3;
  localparam int SIM_S = 10;
  localparam int TMR_W = 14;
  localparam logic [TMR_W-1:0] DISC_TICKS = TMR_W'(DISC_S * 1000000 / TICK_US);
  localparam logic [TMR_W-1:0] SIM_TICKS = TMR_W'(SIM_S * 1000000 / TICK_US);
  localparam int PULSE_NS = 1000;
  localparam logic [TICK_W-1:0] PULSE_CYCLES = TICK_W'(PULSE_NS / CLK_PERIOD_NS);

  // ==========================================================
  // register offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] FWCMD_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] TAPSTAT_OFF = 8'h0C;
  localparam logic [7:0] NODECNT_OFF = 8'h10;
  localparam logic [7:0] DIAGDIS_OFF = 8'h20;

  // ==========================================================
  // field positions and reset values
  localparam int CTRL_DIAG_BIT = 0;
  localparam logic CTRL_DIAG_RST = 1'b1;
  localparam int FW_SELF_BIT = 3;
  localparam int FW_DONE_BIT = 4;
  localparam int STAT_MODE_POS = 0;
  localparam int STAT_OUT_POS = 8;
  localparam int STAT_L2_POS = 12;
  localparam int STAT_REFUSED_BIT = 15;
  localparam int STAT_BAD_POS = 16;
  localparam int NODECNT_L2MASK_POS = 8;

  // ==========================================================
  // types
  typedef enum logic [1:0] {MODE_STARTUP, MODE_OPER, MODE_SAFE, MODE_FWUPD} sttm_mode_type;
  typedef enum logic [1:0] {TAP_SAFE, TAP_OPER, TAP_FAULT} sttm_tap_type;

endpackage

/* File: src/sttm_top.sv */
// safety tap channel monitor: channel modes, tap supervision, apb registers
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
module sttm_top #(
  parameter int unsigned TICK_CYCLES = sttm_pkg::TICK_CYCLES_DEF // system cycles per timer tick
) (
  input wire logic SYS_CLK, // system clock
  input wire logic RST, // synchronous reset, high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error on unmapped address
  input wire logic [sttm_pkg::NUM_CH-1:0][31:0] NODE_PRESENT, // nodes answering at start up
  input wire logic [sttm_pkg::NUM_CH-1:0][31:0] NODE_LEVEL2, // node speaks level 2.0
  input wire logic [sttm_pkg::NUM_CH-1:0][31:0] NODE_VALID, // node safety condition valid
  output logic [sttm_pkg::NUM_CH-1:0] CH_STATUS, // safety status per channel
  output logic [sttm_pkg::NUM_CH-1:0][31:0] DIAG_EN, // automatic diagnostics per node
  input wire logic [1:0] DSOS_IN, // dual_switched_output_signal inputs
  output logic DSOS_RED, // dual tap indicator red
  output logic DSOS_GREEN, // dual tap indicator green
  output logic [1:0] DCT_DRIVE, // dry_contact_input_tap 24V drive
  input wire logic [1:0] DCT_MON, // dry contact monitoring inputs
  output logic DCT_RED, // dry tap indicator red
  output logic DCT_GREEN, // dry tap indicator green
  input wire logic PASS_LINK_IN, // passive tap link side in
  output logic PASS_DEV_OUT, // passive tap device side out
  input wire logic PASS_DEV_IN, // passive tap device side in
  output logic PASS_LINK_OUT // passive tap link side out
);
  import sttm_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    sttm_mode_type [NUM_CH-1:0] mode;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt;
    logic [NUM_CH-1:0][31:0] l2;
    logic [NUM_CH-1:0][31:0] dis;
    logic diag_on;
    logic refused;
    logic [TICK_W-1:0] tick_cnt;
    sttm_tap_type ds_st;
    logic [TMR_W-1:0] ds_tmr;
    logic ds_seen_low;
    sttm_tap_type dc_st;
    logic [TMR_W-1:0] dc_tmr;
    logic dc_seen_open;
    logic [1:0] dc_closed;
    logic pass_dev;
    logic pass_link;
    logic [31:0] prdata;
    logic slverr;
  } sttm_state_type;

  sttm_state_type st_reg;
  sttm_state_type st_next;

  // ==========================================================
  // helpers
  function automatic logic [CNT_W-1:0] sttm_seq_count(input logic [31:0] m);
    logic [CNT_W-1:0] n;
    logic run;
    n = '0;
    run = 1'b1;
    for (int i = 0; i < MAX_NODES; i++) begin
      if (run && m[i]) begin
        n = n + CNT_W'(1);
      end else begin
        run = 1'b0;
      end
    end
    return n;
  endfunction

  function automatic logic [31:0] sttm_cnt_mask(input logic [CNT_W-1:0] n);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < MAX_NODES; i++) begin
      m[i] = (CNT_W'(i) < n);
    end
    return m;
  endfunction

  // ==========================================================
  // per channel decode
  logic [NUM_CH-1:0][31:0] pres;
  logic [NUM_CH-1:0] all_l2;
  logic [NUM_CH-1:0] all_valid;
  logic [NUM_CH-1:0] ch_bad;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign pres[c] = sttm_cnt_mask(st_reg.cnt[c]);
    assign all_l2[c] = &(st_reg.l2[c] | ~pres[c]);
    assign all_valid[c] = &(NODE_VALID[c] | ~pres[c]);
    if (c == L2_ONLY_CH) begin : g_l2only
      assign ch_bad[c] = ~all_l2[c];
    end else begin : g_mixed
      assign ch_bad[c] = 1'b0;
    end
    assign CH_STATUS[c] = (st_reg.mode[c] == MODE_OPER);
    assign DIAG_EN[c] = {32{st_reg.diag_on & all_l2[c]}} & pres[c] & st_reg.l2[c]
      & ~st_reg.dis[c];
  end

  // ==========================================================
  // apb decode
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [NUM_CH-1:0] fw_node_req;
  logic fw_self_req;
  logic fw_done;
  logic all_safe;

  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE;
  assign mapped = (PADDR == CTRL_OFF) || (PADDR == FWCMD_OFF) || (PADDR == STAT_OFF)
    || (PADDR == TAPSTAT_OFF) || (PADDR == NODECNT_OFF) || (PADDR == NODECNT_OFF + 8'h04)
    || (PADDR == NODECNT_OFF + 8'h08) || (PADDR == DIAGDIS_OFF)
    || (PADDR == DIAGDIS_OFF + 8'h04) || (PADDR == DIAGDIS_OFF + 8'h08);
  assign fw_node_req = (wr_en && PADDR == FWCMD_OFF) ? PWDATA[NUM_CH-1:0] : '0;
  assign fw_self_req = wr_en && PADDR == FWCMD_OFF && PWDATA[FW_SELF_BIT];
  assign fw_done = wr_en && PADDR == FWCMD_OFF && PWDATA[FW_DONE_BIT];

  always_comb begin
    all_safe = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      if (st_reg.mode[c] != MODE_SAFE) begin
        all_safe = 1'b0;
      end
    end
  end

  // ==========================================================
  // tap input conditions
  logic tick;
  logic pulse_on;
  logic pulse_end;
  logic ds_agree;
  logic dc_agree;
  logic [1:0] dc_closed_now;

  assign tick = (st_reg.tick_cnt == TICK_W'(TICK_CYCLES - 1));
  assign pulse_on = (st_reg.tick_cnt < PULSE_CYCLES);
  assign pulse_end = (st_reg.tick_cnt == PULSE_CYCLES - TICK_W'(1));
  assign ds_agree = (DSOS_IN[0] == DSOS_IN[1]);
  assign dc_closed_now = pulse_on ? st_reg.dc_closed : DCT_MON;
  assign dc_agree = (dc_closed_now[0] == dc_closed_now[1]);

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + TICK_W'(1);
    st_next.pass_dev = PASS_LINK_IN;
    st_next.pass_link = PASS_DEV_IN;

    // channel modes
    for (int c = 0; c < NUM_CH; c++) begin
      unique case (st_reg.mode[c])
        MODE_STARTUP: begin
          st_next.cnt[c] = sttm_seq_count(NODE_PRESENT[c]);
          st_next.l2[c] = NODE_LEVEL2[c];
          st_next.mode[c] = MODE_SAFE;
        end
        MODE_FWUPD: begin
          if (fw_done) begin
            st_next.mode[c] = MODE_SAFE;
          end
        end
        MODE_OPER, MODE_SAFE: begin
          if ((fw_self_req && all_safe) || (fw_node_req[c] && st_reg.mode[c] == MODE_SAFE)) begin
            st_next.mode[c] = MODE_FWUPD;
          end else if (st_reg.cnt[c] != '0 && all_valid[c] && !ch_bad[c]) begin
            st_next.mode[c] = MODE_OPER;
          end else begin
            st_next.mode[c] = MODE_SAFE;
          end
        end
      endcase
    end

    // registers written by software
    if (wr_en && PADDR == CTRL_OFF) begin
      st_next.diag_on = PWDATA[CTRL_DIAG_BIT];
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_en && PADDR == DIAGDIS_OFF + 8'(4 * c)) begin
        st_next.dis[c] = PWDATA;
      end
    end
    if (wr_en && PADDR == STAT_OFF && PWDATA[STAT_REFUSED_BIT]) begin
      st_next.refused = 1'b0;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (fw_node_req[c] && st_reg.mode[c] != MODE_SAFE) begin
        st_next.refused = 1'b1;
      end
    end
    if (fw_self_req && !all_safe) begin
      st_next.refused = 1'b1;
    end

    // dual output tap, inputs only observed, never tested
    if (ds_agree || st_reg.ds_st == TAP_FAULT) begin
      st_next.ds_tmr = '0;
    end else if (tick && st_reg.ds_tmr != DISC_TICKS) begin
      st_next.ds_tmr = st_reg.ds_tmr + TMR_W'(1);
    end
    unique case (st_reg.ds_st)
      TAP_SAFE, TAP_OPER: begin
        if (!ds_agree && st_reg.ds_tmr == DISC_TICKS) begin
          st_next.ds_st = TAP_FAULT;
          st_next.ds_seen_low = 1'b0;
        end else if (DSOS_IN == 2'h3) begin
          st_next.ds_st = TAP_OPER;
        end else begin
          st_next.ds_st = TAP_SAFE;
        end
      end
      TAP_FAULT: begin
        if (DSOS_IN == 2'h0) begin
          st_next.ds_seen_low = 1'b1;
        end else if (st_reg.ds_seen_low && DSOS_IN == 2'h3) begin
          st_next.ds_st = TAP_OPER;
        end
      end
      default: begin
        st_next.ds_st = TAP_SAFE;
      end
    endcase

    // dry contact tap
    if (!pulse_on) begin
      st_next.dc_closed = DCT_MON;
    end
    if (st_reg.dc_st == TAP_FAULT) begin
      if (st_reg.dc_seen_open && tick && st_reg.dc_tmr != SIM_TICKS) begin
        st_next.dc_tmr = st_reg.dc_tmr + TMR_W'(1);
      end
    end else if (dc_agree) begin
      st_next.dc_tmr = '0;
    end else if (tick && st_reg.dc_tmr != SIM_TICKS) begin
      st_next.dc_tmr = st_reg.dc_tmr + TMR_W'(1);
    end
    unique case (st_reg.dc_st)
      TAP_SAFE, TAP_OPER: begin
        if ((pulse_end && DCT_MON != 2'h0) || (!dc_agree && st_reg.dc_tmr == SIM_TICKS)) begin
          st_next.dc_st = TAP_FAULT;
          st_next.dc_seen_open = 1'b0;
          st_next.dc_tmr = '0;
        end else if (dc_closed_now == 2'h3) begin
          st_next.dc_st = TAP_OPER;
        end else begin
          st_next.dc_st = TAP_SAFE;
        end
      end
      TAP_FAULT: begin
        if (dc_closed_now == 2'h0) begin
          st_next.dc_seen_open = 1'b1;
          st_next.dc_tmr = '0;
        end else if (st_reg.dc_seen_open && st_reg.dc_tmr == SIM_TICKS) begin
          st_next.dc_seen_open = 1'b0;
        end else if (st_reg.dc_seen_open && dc_closed_now == 2'h3 && !pulse_on) begin
          st_next.dc_st = TAP_OPER;
          st_next.dc_tmr = '0;
        end
      end
      default: begin
        st_next.dc_st = TAP_SAFE;
      end
    endcase

    // read data captured in the setup phase
    if (rd_setup) begin
      st_next.slverr = ~mapped;
      st_next.prdata = '0;
      if (PADDR == CTRL_OFF) begin
        st_next.prdata[CTRL_DIAG_BIT] = st_reg.diag_on;
      end else if (PADDR == STAT_OFF) begin
        for (int c = 0; c < NUM_CH; c++) begin
          st_next.prdata[STAT_MODE_POS + 2 * c +: 2] = st_reg.mode[c];
          st_next.prdata[STAT_OUT_POS + c] = CH_STATUS[c];
          st_next.prdata[STAT_L2_POS + c] = all_l2[c];
          st_next.prdata[STAT_BAD_POS + c] = ch_bad[c];
        end
        st_next.prdata[STAT_REFUSED_BIT] = st_reg.refused;
      end else if (PADDR == TAPSTAT_OFF) begin
        st_next.prdata[3:0] = {st_reg.dc_st, st_reg.ds_st};
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (PADDR == NODECNT_OFF + 8'(4 * c)) begin
          st_next.prdata[CNT_W-1:0] = st_reg.cnt[c];
          st_next.prdata[NODECNT_L2MASK_POS +: 16] = st_reg.l2[c][15:0] & pres[c][15:0];
        end
        if (PADDR == DIAGDIS_OFF + 8'(4 * c)) begin
          st_next.prdata = st_reg.dis[c];
        end
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.diag_on <= CTRL_DIAG_RST;
      st_reg.mode <= {NUM_CH{MODE_STARTUP}};
      st_reg.ds_st <= TAP_SAFE;
      st_reg.dc_st <= TAP_SAFE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign PRDATA = st_reg.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & st_reg.slverr;
  assign DSOS_RED = (st_reg.ds_st != TAP_OPER);
  assign DSOS_GREEN = (st_reg.ds_st == TAP_OPER);
  assign DCT_DRIVE = pulse_on ? 2'h0 : 2'h3;
  assign DCT_RED = (st_reg.dc_st != TAP_OPER);
  assign DCT_GREEN = (st_reg.dc_st == TAP_OPER);
  assign PASS_DEV_OUT = st_reg.pass_dev;
  assign PASS_LINK_OUT = st_reg.pass_link;

endmodule

/* File: verif/sttm_partner.sv */
// far side model: contact devices, link device, run gate
`timescale 1ns/10ps
module sttm_partner (
  input wire logic sys_clk, // system clock
  input wire logic [1:0] dct_drive, // contact supply from tap
  input wire logic [1:0] closed, // contacts closed
  input wire logic stuck, // contacts welded to supply
  output logic [1:0] dct_mon, // monitoring return
  input wire logic [2:0] ch_status, // channel status
  output logic run_en, // machine run permit
  input wire logic dev_out, // link toward device
  output logic dev_in // device reply
);
  // supply returns through a closed contact; a stuck contact returns closed even without supply
  assign dct_mon = stuck ? closed : dct_drive & closed;
  assign run_en = &ch_status;
  initial dev_in = 1'b0;
  always @(posedge sys_clk) begin
    dev_in <= ~dev_out;
  end
endmodule

/* File: verif/sttm_properties.sv */
// port assertions for the safety tap channel monitor
`timescale 1ns/10ps
module sttm_properties import sttm_pkg::*; #(
  parameter int unsigned TICK_CYCLES = 400 // cycles per tick
) (
  input wire logic SYS_CLK, // clock
  input wire logic RST, // reset
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic [7:0] PADDR, // apb address
  input wire logic PSLVERR, // apb error
  input wire logic [sttm_pkg::NUM_CH-1:0][31:0] NODE_VALID, // node valid
  input wire logic [sttm_pkg::NUM_CH-1:0] CH_STATUS, // status
  input wire logic [sttm_pkg::NUM_CH-1:0][31:0] DIAG_EN, // diag enable
  input wire logic [1:0] DSOS_IN, // dual inputs
  input wire logic DSOS_RED, // dual red
  input wire logic DSOS_GREEN, // dual green
  input wire logic [1:0] DCT_DRIVE, // dry drive
  input wire logic [1:0] DCT_MON, // dry monitor
  input wire logic DCT_GREEN, // dry green
  input wire logic PASS_LINK_IN, // link in
  input wire logic PASS_DEV_OUT, // device out
  input wire logic PASS_DEV_IN, // device in
  input wire logic PASS_LINK_OUT // link out
);
  typedef struct packed {
    logic [TICK_W-1:0] low;
    logic [TICK_W-1:0] high;
    logic armed;
  } sttm_chk_type;
  sttm_chk_type s_reg;
  sttm_chk_type s_next;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // =========================================
  // drive run lengths
  always_comb begin
    s_next = s_reg;
    s_next.low = (DCT_DRIVE == 2'b00) ? s_reg.low + 1'b1 : '0;
    s_next.high = (DCT_DRIVE == 2'b11) ? s_reg.high + 1'b1 : '0;
    s_next.armed = s_reg.armed | (DCT_DRIVE == 2'b11);
    if (RST) begin
      s_next = '0;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    s_reg <= s_next;
  end
  // =========================================
  // assertions
  status_safe_a: assert property (1'b1 |=>
    (CH_STATUS & ~$past({NODE_VALID[2][0], NODE_VALID[1][0], NODE_VALID[0][0]})) == 3'h0)
    else $error("status high after invalid node");
  reset_vals_a: assert property (disable iff (1'b0) RST |=> CH_STATUS == 3'h0
    && DIAG_EN == '0 && DCT_DRIVE == 2'h0 && DSOS_RED && !DSOS_GREEN)
    else $error("outputs not at reset values");
  pass_fwd_a: assert property (1'b1 |=> PASS_DEV_OUT == $past(PASS_LINK_IN)
    && PASS_LINK_OUT == $past(PASS_DEV_IN)) else $error("passive tap altered data");
  dual_green_a: assert property (DSOS_GREEN |->
    $past(DSOS_IN) == 2'b11 && !DSOS_RED) else $error("dual green without energy");
  dual_safe_a: assert property (DSOS_IN != 2'b11 |=> !DSOS_GREEN)
    else $error("dual green while not energized");
  pulse_width_a: assert property (s_reg.armed && $rose(DCT_DRIVE[0]) |->
    s_reg.low == PULSE_CYCLES) else $error("test pulse width wrong");
  pulse_gap_a: assert property ($fell(DCT_DRIVE[0]) |->
    s_reg.high == TICK_W'(TICK_CYCLES) - PULSE_CYCLES) else $error("pulse period wrong");
  dry_open_a: assert property ((DCT_DRIVE == 2'b11 && DCT_MON != 2'b11) [*2] |=>
    !DCT_GREEN) else $error("dry green with open contact");
  slverr_map_a: assert property (PSEL && PENABLE |-> PSLVERR == !(PADDR inside {8'h00,
    8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28}))
    else $error("error flag wrong for address");
  cover property (CH_STATUS == 3'b011);
  cover property ($rose(DCT_GREEN));
  cover property (PSEL && PENABLE && PSLVERR);
endmodule
bind sttm_top sttm_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.SYS_CLK(SYS_CLK),
  .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PSLVERR(PSLVERR),
  .NODE_VALID(NODE_VALID), .CH_STATUS(CH_STATUS), .DIAG_EN(DIAG_EN), .DSOS_IN(DSOS_IN),
  .DSOS_RED(DSOS_RED), .DSOS_GREEN(DSOS_GREEN), .DCT_DRIVE(DCT_DRIVE), .DCT_MON(DCT_MON),
  .DCT_GREEN(DCT_GREEN), .PASS_LINK_IN(PASS_LINK_IN), .PASS_DEV_OUT(PASS_DEV_OUT),
  .PASS_DEV_IN(PASS_DEV_IN), .PASS_LINK_OUT(PASS_LINK_OUT));

/* File: verif/tb_safety_tap_channel_monitor.sv */
// self-checking bench for the safety tap channel monitor
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch at %0t: got %h, expected %h", $time, (a), (b)); end end
`define WAITF(c) for (k = 0; k < 4000 && (c) !== 1'b1; k++) @(posedge SYS_CLK); \
  if ((c) !== 1'b1) begin miscompares++; report_and_stop(); end
module tb_safety_tap_channel_monitor;
  import sttm_pkg::*;
  localparam int TICK = 400;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic [31:0] rd;
  logic PREADY, PSLVERR, err, dr, dg, dsr, dsg, run_en, pdo, pdi, plo;
  logic [NUM_CH-1:0][31:0] np = {32'h3, 32'h3, 32'hB};
  logic [NUM_CH-1:0][31:0] nl = {32'h1, 32'h1, 32'h3};
  logic [NUM_CH-1:0][31:0] nv = '1;
  logic [NUM_CH-1:0][31:0] de;
  logic [NUM_CH-1:0] st;
  logic [1:0] dsos = 2'b00;
  logic [1:0] closed = 2'b00;
  logic [1:0] drv, mon;
  logic stuck = 1'b0;
  logic pli = 1'b0;
  int miscompares = 0;
  int check_count = 0;
  int k;
  always #2.5 SYS_CLK = ~SYS_CLK;
  sttm_top #(.TICK_CYCLES(TICK)) dut (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .NODE_PRESENT(np), .NODE_LEVEL2(nl),
    .NODE_VALID(nv), .CH_STATUS(st), .DIAG_EN(de), .DSOS_IN(dsos), .DSOS_RED(dsr),
    .DSOS_GREEN(dsg), .DCT_DRIVE(drv), .DCT_MON(mon), .DCT_RED(dr), .DCT_GREEN(dg),
    .PASS_LINK_IN(pli), .PASS_DEV_OUT(pdo), .PASS_DEV_IN(pdi), .PASS_LINK_OUT(plo));
  sttm_partner u_far (.sys_clk(SYS_CLK), .dct_drive(drv), .closed(closed), .stuck(stuck),
    .dct_mon(mon), .ch_status(st), .run_en(run_en), .dev_out(pdo), .dev_in(pdi));
  // =========================================
  // tasks
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    `WAITF(PREADY)
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // =========================================
  // sequence
  initial begin
    cyc(5);
    RST <= 1'b0;
    cyc(3);
    rdc(CTRL_OFF, 32'h1);
    rdc(STAT_OFF, 32'h00041325);
    `CHK(st, 3'b011)
    `CHK(run_en, 1'b0)
    rdc(NODECNT_OFF, 32'h302);
    rdc(NODECNT_OFF + 8'h04, 32'h102);
    `CHK(de[0], 32'h3)
    `CHK(de[1], 32'h0)
    apb(1'b1, DIAGDIS_OFF, 32'h1);
    rdc(DIAGDIS_OFF, 32'h1);
    `CHK(de[0], 32'h2)
    apb(1'b1, CTRL_OFF, 32'h0);
    rdc(CTRL_OFF, 32'h0);
    `CHK(de[0], 32'h0)
    nv[0] <= 32'hFFFFFFF7;
    cyc(2);
    `CHK(st, 3'b011)
    nv[0] <= 32'hFFFFFFF5;
    cyc(2);
    `CHK(st, 3'b010)
    nv[0] <= '1;
    apb(1'b1, FWCMD_OFF, 32'h9);
    rdc(STAT_OFF, 32'h00049325);
    apb(1'b1, FWCMD_OFF, 32'h4);
    rdc(STAT_OFF, 32'h00049335);
    apb(1'b1, FWCMD_OFF, 32'h10);
    nv <= '0;
    cyc(2);
    apb(1'b1, FWCMD_OFF, 32'h8);
    rdc(STAT_OFF, 32'h0004903F);
    nv <= '1;
    apb(1'b1, FWCMD_OFF, 32'h10);
    apb(1'b1, STAT_OFF, 32'h8000);
    rdc(STAT_OFF, 32'h00041325);
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    `CHK(err, 1'b1)
    rdc(8'h40, 32'h0);
    `CHK(err, 1'b1)
    dsos <= 2'b11;
    cyc(2);
    `CHK({dsr, dsg}, 2'b01)
    dsos <= 2'b01;
    cyc(2);
    `CHK({dsr, dsg}, 2'b10)
    dsos <= 2'b11;
    cyc(2);
    `CHK({dsr, dsg}, 2'b01)
    dsos <= 2'b00;
    cyc(2);
    `CHK({dsr, dsg}, 2'b10)
    closed <= 2'b11;
    `WAITF(dg)
    `CHK(dr, 1'b0)
    rdc(TAPSTAT_OFF, 32'h4);
    closed <= 2'b01;
    `WAITF(dr)
    `CHK(dg, 1'b0)
    closed <= 2'b00;
    stuck <= 1'b1;
    cyc(TICK);
    closed <= 2'b11;
    cyc(2 * TICK);
    rdc(TAPSTAT_OFF, 32'h8);
    stuck <= 1'b0;
    closed <= 2'b00;
    cyc(TICK);
    closed <= 2'b11;
    `WAITF(dg)
    rdc(TAPSTAT_OFF, 32'h4);
    for (k = 0; k < 2; k++) begin
      pli <= k[0];
      cyc(4);
      `CHK({pdo, plo}, {k[0], ~k[0]})
    end
    RST <= 1'b1;
    np[1] <= 32'hFFFFFFFF;
    nl[2] <= 32'h3;
    cyc(5);
    RST <= 1'b0;
    cyc(3);
    rdc(NODECNT_OFF + 8'h04, 32'h120);
    `CHK(st, 3'b111)
    `CHK(run_en, 1'b1)
    report_and_stop();
  end
endmodule
